// [inc/bit_branch_cfg.svh]
// Purpose: named constants of the bit and branch execution unit
// Assumes: included by bare name after the package
// Notes: opcodes, cycle counts, status bit positions, bus offsets
`ifndef BIT_BRANCH_CFG_SVH
`define BIT_BRANCH_CFG_SVH
`define OP_CARRY_AND  8'h8B
`define OP_CARRY_OR   8'h6B
`define OP_CARRY_XOR  8'hAB
`define OP_LOAD_CARRY 8'hCB
`define OP_BIT_DP     8'h0C
`define OP_BIT_ABS    8'h1C
`define OP_ACC_CLR    8'h2B
`define OP_ACC_SET    8'h0B
`define OP_C_CLR      8'h20
`define OP_C_SET      8'hA0
`define OP_G_CLR      8'h40
`define OP_G_SET      8'hC0
`define OP_V_CLR      8'h80
`define OP_MEM_NOT    8'h4B
`define OP_STORE_C    8'hEB
`define OP_TEST_CLR   8'h5C
`define OP_TEST_SET   8'h3C
`define OP_BR_C0      8'h50
`define OP_BR_C1      8'hD0
`define OP_BR_Z1      8'hF0
`define OP_BR_Z0      8'h70
`define OP_BR_N1      8'h90
`define NIB_DP_BIT    4'h1
`define NIB_BR_ACC    4'h2
`define NIB_BR_DP     4'h3
`define CY_2          4'h2
`define CY_4          4'h4
`define CY_5          4'h5
`define CY_6          4'h6
`define CY_TAKEN      4'h2
`define PSW_N         3'h7
`define PSW_V         3'h6
`define PSW_G         3'h5
`define PSW_H         3'h3
`define PSW_Z         3'h1
`define PSW_C         3'h0
`define REG_CTRL      5'h00
`define REG_STATUS    5'h04
`define REG_PC        5'h08
`define REG_ACC       5'h0C
`define REG_PSW       5'h10
`define PC_RST        16'h0000
`endif

// [inc/bit_branch_pkg.sv]
// Purpose: types of the bit and branch execution unit
// Assumes: nothing
// Notes: states, instruction kinds, data memory request
`default_nettype none
package bit_branch_pkg;
    typedef enum logic [2:0] {
        S_OP = 3'b000, S_B1 = 3'b001, S_B2 = 3'b010,
        S_RD = 3'b011, S_WR = 3'b100, S_PAD = 3'b101
    } state_t;
    typedef enum logic [3:0] {
        K_ILL = 4'b0000, K_FLAG = 4'b0001, K_CBIT = 4'b0010, K_NOT = 4'b0011,
        K_STC = 4'b0100, K_BITD = 4'b0101, K_BITA = 4'b0110, K_TST = 4'b0111,
        K_DPBIT = 4'b1000, K_ABIT = 4'b1001, K_BRF = 4'b1010, K_BBA = 4'b1011,
        K_BBD = 4'b1100
    } kind_t;
    typedef struct packed {
        logic [3:0] cyc;
        logic [1:0] len;
        kind_t      kind;
    } dec_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        we;
        logic        re;
    } dmem_req_t;
endpackage
`default_nettype wire

// [rtl/bit_branch_exec.sv]
// Purpose: executes the bit-manipulation and relative-branch groups
// Assumes: program and data memory answer in the same cycle
// Notes: run, pc, acc and flags reachable over Avalon-MM
// Notes on behaviour
// - 8B: carry becomes carry AND bit, or AND inverted bit.
// - 6B: carry becomes carry OR bit, or OR inverted bit.
// - AB: carry becomes carry XOR bit, or XOR inverted bit.
// - CB: carry loaded from bit or from its complement.
// - bit test: Z from A AND M, N from M7, V from M6.
// - direct-page bit clear writes 0, set writes 1; four cycles.
// - 2B clears, 0B sets an accumulator bit; two cycles.
// - 20 clears carry, A0 sets it; nothing else changes.
// - 40 clears page select, C0 sets it.
// - 80 clears overflow and half-carry.
// - 4B inverts a memory bit in place; flags untouched.
// - EB writes carry into a memory bit, other bits kept.
// - 5C: N,Z from A minus M, then writes M AND NOT A.
// - 3C: N,Z from A minus M, then writes M OR A.
// - branch on bit clear jumps only when the bit is 0.
// - branch on bit set jumps on 1; 4/6 and 5/7 cycles.
// - 50 and D0 branch on carry 0 and 1; 2/4 cycles.
// - F0 branches on zero set, 70 on zero clear; 2/4.
// - 90 branches when negative is set; 2/4 cycles.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "bit_branch_cfg.svh"
module bit_branch_exec (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    output logic [15:0]                   prog_addr,
    input  wire logic [7:0]               prog_data,
    output bit_branch_pkg::dmem_req_t     dmem_req,
    input  wire logic [7:0]               dmem_rdata,
    input  wire logic [4:0]               address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    output logic [31:0]                   readdata,
    output logic                          waitrequest
);
    bit_branch_pkg::state_t    state_r, state_nxt;
    bit_branch_pkg::kind_t     kind_r, kind_nxt;
    bit_branch_pkg::dec_t      dec_w;
    bit_branch_pkg::dmem_req_t dreq_r, dreq_nxt;
    logic [3:0]  cnt_r, cnt_nxt, tot_r, tot_nxt, tot_v;
    logic [15:0] pc_r, pc_nxt;
    logic [7:0]  acc_r, acc_nxt, psw_r, psw_nxt;
    logic [7:0]  op_r, op_nxt, b1_r, b1_nxt, b2_r, b2_nxt;
    logic [7:0]  mask, wval, diff;
    logic [2:0]  bidx;
    logic        sel_bit, taken, work_done, ill_r, ill_nxt;
    logic        run_r, run_nxt, ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        idle, wr_ok, ill_clr, fetch, done;
    // opcode table: cycle count when not taken, byte length, kind
    function automatic bit_branch_pkg::dec_t dec(input logic [7:0] op);
        bit_branch_pkg::dec_t d;
        d = '{`CY_2, 2'h1, bit_branch_pkg::K_ILL};
        case (op)
            `OP_CARRY_AND, `OP_LOAD_CARRY: d = '{`CY_4, 2'h3, bit_branch_pkg::K_CBIT};
            `OP_CARRY_OR, `OP_CARRY_XOR:   d = '{`CY_5, 2'h3, bit_branch_pkg::K_CBIT};
            `OP_MEM_NOT:  d = '{`CY_5, 2'h3, bit_branch_pkg::K_NOT};
            `OP_STORE_C:  d = '{`CY_6, 2'h3, bit_branch_pkg::K_STC};
            `OP_BIT_DP:   d = '{`CY_4, 2'h2, bit_branch_pkg::K_BITD};
            `OP_BIT_ABS:  d = '{`CY_5, 2'h3, bit_branch_pkg::K_BITA};
            `OP_TEST_CLR, `OP_TEST_SET:    d = '{`CY_6, 2'h3, bit_branch_pkg::K_TST};
            `OP_ACC_CLR, `OP_ACC_SET:      d = '{`CY_2, 2'h2, bit_branch_pkg::K_ABIT};
            `OP_C_CLR, `OP_C_SET, `OP_G_CLR, `OP_G_SET, `OP_V_CLR:
                d = '{`CY_2, 2'h1, bit_branch_pkg::K_FLAG};
            `OP_BR_C0, `OP_BR_C1, `OP_BR_Z1, `OP_BR_Z0, `OP_BR_N1:
                d = '{`CY_2, 2'h2, bit_branch_pkg::K_BRF};
            default: begin
                // bit number from opcode bits 7..5
                case (op[3:0])
                    `NIB_DP_BIT: d = '{`CY_4, 2'h2, bit_branch_pkg::K_DPBIT};
                    `NIB_BR_ACC: d = '{`CY_4, 2'h2, bit_branch_pkg::K_BBA};
                    `NIB_BR_DP:  d = '{`CY_5, 2'h3, bit_branch_pkg::K_BBD};
                    default:     d = '{`CY_2, 2'h1, bit_branch_pkg::K_ILL};
                endcase
            end
        endcase
        return d;
    endfunction
    // signed offset added to a pc already past the branch
    function automatic logic [15:0] rel_add(input logic [15:0] base, input logic [7:0] rel);
        return base + {{8{rel[7]}}, rel};
    endfunction
    // one-hot mask of a bit number
    function automatic logic [7:0] bmask(input logic [2:0] idx);
        return 8'h01 << idx;
    endfunction
    assign dec_w       = dec(prog_data);
    assign prog_addr   = pc_r;
    assign dmem_req    = dreq_r;
    assign readdata    = rdata_r;
    assign waitrequest = (read | write) & ~ack_r;
    assign idle        = (state_r == bit_branch_pkg::S_OP) & ~run_r;
    // host may only touch pc, acc and flags between instructions while halted
    assign wr_ok       = ack_r & write & idle;
    assign ill_clr     = ack_r & write & (address == `REG_STATUS) & writedata[1];
    assign fetch       = (state_r == bit_branch_pkg::S_OP) & run_r;
    assign done        = (state_r != bit_branch_pkg::S_OP) & (state_nxt == bit_branch_pkg::S_OP);
    // dp forms take the bit from the opcode, M.bit forms from operand
    assign bidx    = (kind_r == bit_branch_pkg::K_DPBIT || kind_r == bit_branch_pkg::K_BBD) ?
                     op_r[7:5] : b2_r[7:5];
    assign mask    = bmask(bidx);
    assign sel_bit = dmem_rdata[bidx];
    assign diff    = acc_r - dmem_rdata;
    // instruction sequencer: one state per byte fetched or memory access
    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        cnt_nxt   = cnt_r + 4'h1;
        tot_nxt   = tot_r;
        tot_v     = tot_r;
        pc_nxt    = pc_r;
        acc_nxt   = acc_r;
        psw_nxt   = psw_r;
        op_nxt    = op_r;
        b1_nxt    = b1_r;
        b2_nxt    = b2_r;
        dreq_nxt  = '0;
        ill_nxt   = ill_r & ~ill_clr;
        wval      = 8'h00;
        taken     = 1'b0;
        work_done = 1'b0;
        case (state_r)
            bit_branch_pkg::S_OP: begin
                if (run_r) begin
                    op_nxt   = prog_data;
                    kind_nxt = dec_w.kind;
                    tot_nxt  = dec_w.cyc;
                    cnt_nxt  = 4'h1; // restart: the opcode cycle is cycle one of the table count
                    pc_nxt   = pc_r + 16'h0001;
                    state_nxt = (dec_w.len == 2'h1) ? bit_branch_pkg::S_PAD : bit_branch_pkg::S_B1;
                    case (prog_data)
                        `OP_C_CLR: psw_nxt[`PSW_C] = 1'b0;
                        `OP_C_SET: psw_nxt[`PSW_C] = 1'b1;
                        `OP_G_CLR: psw_nxt[`PSW_G] = 1'b0;
                        `OP_G_SET: psw_nxt[`PSW_G] = 1'b1;
                        `OP_V_CLR: begin
                            psw_nxt[`PSW_V] = 1'b0;
                            psw_nxt[`PSW_H] = 1'b0;
                        end
                        default: ;
                    endcase
                    // unknown opcodes run as two-cycle no-ops; set wins over clear
                    if (dec_w.kind == bit_branch_pkg::K_ILL)
                        ill_nxt = 1'b1;
                end else begin
                    cnt_nxt = 4'h0;
                    if (wr_ok && address == `REG_PC)
                        pc_nxt = writedata[15:0];
                    if (wr_ok && address == `REG_ACC)
                        acc_nxt = writedata[7:0];
                    if (wr_ok && address == `REG_PSW)
                        psw_nxt = writedata[7:0];
                end
            end
            bit_branch_pkg::S_B1: begin
                b1_nxt = prog_data;
                pc_nxt = pc_r + 16'h0001;
                case (kind_r)
                    bit_branch_pkg::K_ABIT: begin
                        acc_nxt = (op_r == `OP_ACC_SET) ? (acc_r | bmask(prog_data[2:0])) :
                                  (acc_r & ~bmask(prog_data[2:0]));
                        work_done = 1'b1;
                    end
                    bit_branch_pkg::K_BRF: begin
                        case (op_r)
                            `OP_BR_C0: taken = ~psw_r[`PSW_C];
                            `OP_BR_C1: taken = psw_r[`PSW_C];
                            `OP_BR_Z1: taken = psw_r[`PSW_Z];
                            `OP_BR_Z0: taken = ~psw_r[`PSW_Z];
                            `OP_BR_N1: taken = psw_r[`PSW_N];
                            default:   taken = 1'b0;
                        endcase
                        work_done = 1'b1;
                    end
                    bit_branch_pkg::K_BBA: begin
                        // bit 4 of the opcode selects clear or set
                        taken     = acc_r[op_r[7:5]] ^ op_r[4];
                        work_done = 1'b1;
                    end
                    bit_branch_pkg::K_DPBIT, bit_branch_pkg::K_BITD: begin
                        dreq_nxt.addr = {7'h00, psw_r[`PSW_G], prog_data};
                        dreq_nxt.re   = 1'b1;
                        state_nxt     = bit_branch_pkg::S_RD;
                    end
                    default: state_nxt = bit_branch_pkg::S_B2;
                endcase
                // pc now points past the offset byte
                if (taken)
                    pc_nxt = rel_add(pc_r + 16'h0001, prog_data);
            end
            bit_branch_pkg::S_B2: begin
                b2_nxt      = prog_data;
                pc_nxt      = pc_r + 16'h0001;
                dreq_nxt.re = 1'b1;
                case (kind_r)
                    bit_branch_pkg::K_BBD:  dreq_nxt.addr = {7'h00, psw_r[`PSW_G], b1_r};
                    bit_branch_pkg::K_BITA,
                    bit_branch_pkg::K_TST:  dreq_nxt.addr = {prog_data, b1_r};
                    default:                dreq_nxt.addr = {4'h0, prog_data[3:0], b1_r};
                endcase
                state_nxt = bit_branch_pkg::S_RD;
            end
            bit_branch_pkg::S_RD: begin
                work_done = 1'b1;
                case (kind_r)
                    bit_branch_pkg::K_CBIT: begin
                        // operand bit 4 picks the inverted variant
                        case (op_r)
                            `OP_CARRY_AND: psw_nxt[`PSW_C] = psw_r[`PSW_C] & (sel_bit ^ b2_r[4]);
                            `OP_CARRY_OR:  psw_nxt[`PSW_C] = psw_r[`PSW_C] | (sel_bit ^ b2_r[4]);
                            `OP_CARRY_XOR: psw_nxt[`PSW_C] = psw_r[`PSW_C] ^ (sel_bit ^ b2_r[4]);
                            default:       psw_nxt[`PSW_C] = sel_bit ^ b2_r[4];
                        endcase
                    end
                    bit_branch_pkg::K_BITD, bit_branch_pkg::K_BITA: begin
                        psw_nxt[`PSW_Z] = (acc_r & dmem_rdata) == 8'h00;
                        psw_nxt[`PSW_N] = dmem_rdata[7];
                        psw_nxt[`PSW_V] = dmem_rdata[6];
                    end
                    bit_branch_pkg::K_BBD: begin
                        taken = sel_bit ^ op_r[4];
                        if (taken)
                            pc_nxt = rel_add(pc_r, b2_r);
                    end
                    default: begin
                        work_done = 1'b0;
                        case (kind_r)
                            bit_branch_pkg::K_TST: begin
                                psw_nxt[`PSW_N] = diff[7];
                                psw_nxt[`PSW_Z] = diff == 8'h00;
                                wval = (op_r == `OP_TEST_CLR) ? (dmem_rdata & ~acc_r) : (dmem_rdata | acc_r);
                            end
                            bit_branch_pkg::K_DPBIT: wval = op_r[4] ? (dmem_rdata & ~mask) : (dmem_rdata | mask);
                            bit_branch_pkg::K_NOT:   wval = dmem_rdata ^ mask;
                            default: wval = psw_r[`PSW_C] ? (dmem_rdata | mask) : (dmem_rdata & ~mask);
                        endcase
                        dreq_nxt  = '{dreq_r.addr, wval, 1'b1, 1'b0};
                        state_nxt = bit_branch_pkg::S_WR;
                    end
                endcase
            end
            bit_branch_pkg::S_WR:  work_done = 1'b1;
            bit_branch_pkg::S_PAD: work_done = 1'b1;
            default:               state_nxt = bit_branch_pkg::S_OP;
        endcase
        // taken branches add two cycles; pad until the table count is met
        if (work_done) begin
            tot_v     = taken ? (tot_r + `CY_TAKEN) : tot_r;
            tot_nxt   = tot_v;
            state_nxt = (cnt_r + 4'h1 == tot_v) ? bit_branch_pkg::S_OP : bit_branch_pkg::S_PAD;
        end
    end
    // sequencer registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= bit_branch_pkg::S_OP;
            kind_r  <= bit_branch_pkg::K_ILL;
            cnt_r   <= 4'h0;
            tot_r   <= 4'h0;
            pc_r    <= `PC_RST;
            acc_r   <= 8'h00;
            psw_r   <= 8'h00;
            op_r    <= 8'h00;
            b1_r    <= 8'h00;
            b2_r    <= 8'h00;
            dreq_r  <= '0;
            ill_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            cnt_r   <= cnt_nxt;
            tot_r   <= tot_nxt;
            pc_r    <= pc_nxt;
            acc_r   <= acc_nxt;
            psw_r   <= psw_nxt;
            op_r    <= op_nxt;
            b1_r    <= b1_nxt;
            b2_r    <= b2_nxt;
            dreq_r  <= dreq_nxt;
            ill_r   <= ill_nxt;
        end
    end
    // bus slave: one wait cycle, read data captured as the wait drops
    always_comb begin
        ack_nxt   = (read | write) & ~ack_r;
        run_nxt   = run_r;
        rdata_nxt = rdata_r;
        if (ack_r && write && address == `REG_CTRL)
            run_nxt = writedata[0];
        if (ack_nxt && read) begin
            case (address)
                `REG_CTRL:   rdata_nxt = {31'h0, run_r};
                `REG_STATUS: rdata_nxt = {30'h0, ill_r, state_r != bit_branch_pkg::S_OP};
                `REG_PC:     rdata_nxt = {16'h0, pc_r};
                `REG_ACC:    rdata_nxt = {24'h0, acc_r};
                `REG_PSW:    rdata_nxt = {24'h0, psw_r};
                default:     rdata_nxt = 32'h0;
            endcase
        end
    end
    // bus slave registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_r   <= 1'b0;
            run_r   <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r   <= ack_nxt;
            run_r   <= run_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_carry_clear: assert property ((fetch && prog_data == `OP_C_CLR)
        |=> psw_r == ($past(psw_r) & ~bmask(`PSW_C)))
        else $error("carry clear changed flags");
    a_carry_set: assert property ((fetch && prog_data == `OP_C_SET) |-> ##2 psw_r[`PSW_C])
        else $error("carry not set");
    a_page_set: assert property ((fetch && prog_data == `OP_G_SET) |-> ##2 psw_r[`PSW_G])
        else $error("page select not set");
    a_ovf_clear: assert property ((done && op_r == `OP_V_CLR) |-> !psw_r[`PSW_V] && !psw_r[`PSW_H])
        else $error("overflow or half-carry left set");
    a_flag_len: assert property ((fetch && prog_data == `OP_C_CLR) |=> !fetch ##1 fetch || !run_r)
        else $error("flag op not two cycles");
    a_brc_taken: assert property ((fetch && prog_data == `OP_BR_C0 && !psw_r[`PSW_C])
        |=> (state_r != bit_branch_pkg::S_OP)[*3] ##1 state_r == bit_branch_pkg::S_OP)
        else $error("taken carry branch not four cycles");
    a_brc_skip: assert property ((fetch && prog_data == `OP_BR_C1 && !psw_r[`PSW_C])
        |-> ##2 pc_r == $past(pc_r, 2) + 16'h0002)
        else $error("untaken branch moved pc wrongly");
    a_acc_set: assert property ((done && op_r == `OP_ACC_SET) |=> acc_r[b1_r[2:0]])
        else $error("accumulator bit not set");
    a_not_write: assert property ((state_r == bit_branch_pkg::S_RD && kind_r == bit_branch_pkg::K_NOT)
        |=> dmem_req.we && dmem_req.wdata[$past(bidx)] != $past(sel_bit))
        else $error("bit not complemented");
    a_bbs_skip: assert property ((fetch && prog_data[3:0] == `NIB_BR_ACC && !prog_data[4]
        && !acc_r[prog_data[7:5]]) |=> (state_r != bit_branch_pkg::S_OP)[*3]
        ##1 state_r == bit_branch_pkg::S_OP)
        else $error("bit branch not taken length wrong");
    c_zero_taken: cover property (fetch && prog_data == `OP_BR_Z1 && psw_r[`PSW_Z] ##4 fetch);
    c_test_set: cover property (dmem_req.we && op_r == `OP_TEST_SET);
    c_bit_dp: cover property (done && op_r == `OP_BIT_DP);
endmodule
`default_nettype wire

// [sim/branch_mem_model.sv]
// Purpose: program and data memory standing behind the core
// Assumes: 256-byte spaces, both read combinationally in the same cycle
// Notes: read data without a read request flips every cycle, so stale data cannot pass by luck
`timescale 1ns/10ps
`default_nettype none
module branch_mem_model (
    input  wire logic                      clk,
    input  wire logic [15:0]               prog_addr,
    output logic [7:0]                     prog_data,
    input  wire bit_branch_pkg::dmem_req_t dmem_req,
    output logic [7:0]                     dmem_rdata
);
    logic [7:0] prog [0:255];
    logic [7:0] data [0:255];
    logic       flip_r = 1'b0;
    // writes land on the edge that sees the one-cycle write request
    always @(posedge clk) begin
        flip_r <= ~flip_r;
        if (dmem_req.we === 1'b1) begin
            data[dmem_req.addr[7:0]] <= dmem_req.wdata;
        end
    end
    assign prog_data  = prog[prog_addr[7:0]];
    assign dmem_rdata = dmem_req.re ? data[dmem_req.addr[7:0]] : {8{flip_r}};
endmodule
`default_nettype wire

// [sim/test_bit_branch_exec.sv]
// Purpose: self-checking bench for the bit and branch execution unit
// Assumes: two programs exercising every rule family, judged through the bus and memory
// Notes: carry chain results are made visible by storing carry into memory bits
`timescale 1ns/10ps
`default_nettype none
module test_bit_branch_exec;
    logic clk = 1'b0, sys_rst = 1'b1, read = 1'b0, write = 1'b0, waitrequest;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [15:0] prog_addr;
    logic [7:0] prog_data, dmem_rdata;
    bit_branch_pkg::dmem_req_t dmem_req;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    // loop at 3D; skipped A0 bytes would set carry if a branch went astray
    localparam logic [503:0] CODE = {256'hA08B40608B40706B4060AB4060EB4120CB4070CB4060EB41004B41E0205002A0,
                                     248'hA0D0025142A143A34301A03C44005C4500F002A0A00C4680C09002A0A0F0FE};
    // second program at 80, loop at A3; again skipped A0 bytes would set carry
    localparam logic [295:0] CODE2 = 296'h0B032B046202A0A09202A0A00200134702A0A01C48007002406B4970AB4970EB4A20FFF0FE;
    always #20 clk = ~clk;
    bit_branch_exec i_bit_branch_exec (.clk(clk), .sys_rst(sys_rst), .prog_addr(prog_addr),
        .prog_data(prog_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
    branch_mem_model i_branch_mem_model (.clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // bus cycles hold the request until waitrequest is seen low at a rising edge
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a; writedata <= d; write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a; read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
    endtask
    // cut a hang short; the program needs a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic t_reset_and_map();
        bus_rd(5'h08, rd); check(rd, 32'h0);
        bus_rd(5'h10, rd); check(rd, 32'h0);
        bus_wr(5'h14, 32'hFFFF_FFFF);
        bus_rd(5'h14, rd); check(rd, 32'h0);
        bus_wr(5'h0C, 32'h0000_000F);
        bus_rd(5'h0C, rd); check(rd, 32'h0000_000F);
    endtask
    task automatic t_run_program();
        int i;
        for (i = 0; i < 256; i++) i_branch_mem_model.prog[i] = 8'h00;
        for (i = 0; i < 63; i++) i_branch_mem_model.prog[i] = CODE[503 - 8*i -: 8];
        for (i = 0; i < 256; i++) i_branch_mem_model.data[i] = 8'h00;
        i_branch_mem_model.data[8'h40] = 8'h08;
        i_branch_mem_model.data[8'h41] = 8'h02;
        i_branch_mem_model.data[8'h42] = 8'hFF;
        i_branch_mem_model.data[8'h44] = 8'hF0;
        i_branch_mem_model.data[8'h45] = 8'h0F;
        i_branch_mem_model.data[8'h46] = 8'hC0;
        bus_wr(5'h00, 32'h1);
        repeat (400) @(posedge clk);
        bus_wr(5'h00, 32'h0);
        repeat (20) @(posedge clk);
        // N and Z set, G set, V and H cleared, carry clear after the skips
        bus_rd(5'h10, rd); check(rd, 32'h0000_00A2);
        bus_rd(5'h08, rd); check(rd, 32'h0000_003D);
        bus_rd(5'h0C, rd); check(rd, 32'h0000_000F);
        bus_rd(5'h04, rd); check(rd & 32'h2, 32'h0);
        // bit1 stored 0 after xor, bit0 stored 1 after load, bit7 inverted
        check({24'h0, i_branch_mem_model.data[8'h41]}, 32'h81);
        check({24'h0, i_branch_mem_model.data[8'h42]}, 32'hFB);
        check({24'h0, i_branch_mem_model.data[8'h43]}, 32'h20);
        check({24'h0, i_branch_mem_model.data[8'h44]}, 32'hFF);
        check({24'h0, i_branch_mem_model.data[8'h45]}, 32'h00);
        check({24'h0, i_branch_mem_model.data[8'h40]}, 32'h08);
    endtask
    // accumulator bits, bit-clear branches, inverted carry ops, absolute bit test, illegal opcode
    task automatic t_acc_and_inverted();
        int i;
        for (i = 0; i < 37; i++) i_branch_mem_model.prog[8'h80 + i] = CODE2[295 - 8*i -: 8];
        i_branch_mem_model.data[8'h47] = 8'h00;
        i_branch_mem_model.data[8'h48] = 8'h40;
        i_branch_mem_model.data[8'h49] = 8'h00;
        i_branch_mem_model.data[8'h4A] = 8'hFF;
        bus_wr(5'h08, 32'h0000_0080);
        bus_wr(5'h0C, 32'h0000_0010);
        bus_wr(5'h10, 32'h0000_0020);
        bus_wr(5'h00, 32'h1);
        repeat (200) @(posedge clk);
        bus_wr(5'h00, 32'h0);
        repeat (20) @(posedge clk);
        // V and Z from the bit test, page select cleared, carry clear after the skips
        bus_rd(5'h10, rd); check(rd, 32'h0000_0042);
        bus_rd(5'h08, rd); check(rd, 32'h0000_00A3);
        bus_rd(5'h0C, rd); check(rd, 32'h0000_0008);
        bus_rd(5'h04, rd); check(rd, 32'h0000_0002);
        bus_wr(5'h04, 32'h0000_0002);
        bus_rd(5'h04, rd); check(rd, 32'h0);
        check({24'h0, i_branch_mem_model.data[8'h4A]}, 32'hFD);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_and_map();
        t_run_program();
        t_acc_and_inverted();
        end_of_test();
    end
endmodule
`default_nettype wire
